// ===== adc_mode_and_serial_readout_bench.sv
// Self-checking bench for the ADC mode and serial readout block.
// Assumes adcms_core, adcms_host and the checker are compiled before it.
`timescale 1ns/1ps
`include "adcms_regs.svh"
module adc_mode_and_serial_readout_bench import adcms_pkg::*;;
	logic clk_i, reset_n_i, isel, csel, wref, cs_n, msb, busy, ref_en, fs, sclk, sdi;
	logic [2:0] st, sdo, oe_n;
	logic [15:0] pd;
	adcms_word_t ra, rb, rc;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, q;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [47:0] got;
	logic [15:0] din;
	logic [47:0] exp_q [$];
	int miscompares, cmp_count, cyc;
	adcms_core #(.RES_BITS(16), .CONV_CYC(5)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.interface_select_i(isel), .config_source_select_i(csel), .write_ref_pin_i(wref),
		.chip_select_n_i(cs_n), .parallel_data_i(pd), .parallel_data_msb_o(msb),
		.conversion_start_pair_i(st), .busy_o(busy), .ref_enable_o(ref_en),
		.frame_sync_i(fs), .serial_clock_i(sclk), .serial_in_i(sdi),
		.serial_out_pair_o(sdo), .serial_out_pair_oe_n_o(oe_n), .result_a_i(ra),
		.result_b_i(rb), .result_c_i(rc), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	adcms_host host_u (.clk_i(clk_i), .busy_i(busy), .sdo_i(sdo), .start_o(st),
		.fs_o(fs), .sclk_o(sclk), .sdi_o(sdi));
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic axi(input logic we, input logic [7:0] a, input logic [31:0] d);
		if (we) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		do begin
			@(posedge clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (arready) arvalid <= 1'b0;
		end while (!(bvalid && bready) && !(rvalid && rready));
		q = rdata;
		r = we ? bresp : rresp;
		bready <= 1'b0;
		rready <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic setm(input logic s, input logic c, input logic w);
		isel <= s;
		csel <= c;
		wref <= w;
		repeat (8) @(posedge clk_i);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	initial begin
		{reset_n_i, isel, csel, wref, cs_n, pd, ra, rb, rc} = {5'b01011, 64'h0};
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		void'($urandom(38901));
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		for (int b = 0; b < 2; b++) begin
			setm(b[0], 1'b0, !b[0]);
			chk("ref", !b, ref_en);
			axi(1'b0, `ADCMS_OFF_STATUS, 32'h0);
			chk("mode", {1'b0, b[0]}, q[5:4]);
		end
		$display("test pins done");
		for (int k = 0; k < 3; k++) begin
			{ra, rb, rc, din} <= {$urandom, $urandom};
			host_u.convert(3'h1 << k);
			exp_q.push_back({rc, rb, ra});
			host_u.frame(din, got);
			chk("sdo", exp_q.pop_front(), got);
			axi(1'b0, `ADCMS_OFF_SERIN, 32'h0);
			chk("serin", din, q[15:0]);
			chk("msb", 1'b0, msb);
		end
		$display("test serial done");
		setm(1'b1, 1'b1, 1'b0);
		for (int b = 1; b >= 0; b--) begin
			axi(1'b1, `ADCMS_OFF_CONFIG, b << `ADCMS_REF_ON_BIT);
			repeat (4) @(posedge clk_i);
			chk("ref", {b[0], `ADCMS_RESP_OKAY}, {ref_en, r});
		end
		axi(1'b1, `ADCMS_OFF_STATUS, $urandom);
		chk("bresp", `ADCMS_RESP_SLVERR, r);
		axi(1'b0, 8'h40, 32'h0);
		chk("rresp", {`ADCMS_RESP_SLVERR, 32'h0}, {r, q});
		$display("test register done");
		setm(1'b0, 1'b1, 1'b1);
		for (int k = 0; k < 2; k++) begin
			cs_n <= k[0];
			pd <= k ? 16'h0F0F : din;
			repeat (4) @(posedge clk_i);
			wref <= 1'b0;
			repeat (4) @(posedge clk_i);
			wref <= 1'b1;
			repeat (4) @(posedge clk_i);
			axi(1'b0, `ADCMS_OFF_PARIN, 32'h0);
			chk("parin", din, q[15:0]);
			chk("msb", ra[15], msb);
		end
		$display("test parallel done");
		tally_and_finish();
	end
endmodule // adc_mode_and_serial_readout_bench

// ===== adcms_core.sv
// Top of the ADC digital interface: mode pins, conversion busy, serial readout, AXI4-Lite.
// Assumes pins are asynchronous; analog results arrive on result_*_i from the converter.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "adcms_regs.svh"
module adcms_core import adcms_pkg::*; #(
	parameter int RES_BITS = 16,
	parameter int CONV_CYC = `ADCMS_CONV_CYC
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic interface_select_i,
	input wire logic config_source_select_i,
	input wire logic write_ref_pin_i,
	input wire logic chip_select_n_i,
	input wire logic [15:0] parallel_data_i,
	output logic parallel_data_msb_o,
	input wire logic [2:0] conversion_start_pair_i,
	output logic busy_o,
	output logic ref_enable_o,
	input wire logic frame_sync_i,
	input wire logic serial_clock_i,
	input wire logic serial_in_i,
	output logic [2:0] serial_out_pair_o,
	output logic [2:0] serial_out_pair_oe_n_o,
	input wire logic [15:0] result_a_i,
	input wire logic [15:0] result_b_i,
	input wire logic [15:0] result_c_i,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int NPIN = 11;
	logic [NPIN-1:0] pin_sync;
	adcms_sync #(.WIDTH(NPIN)) u_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.async_i({interface_select_i, config_source_select_i, write_ref_pin_i,
			chip_select_n_i, conversion_start_pair_i, ~frame_sync_i, serial_clock_i,
			serial_in_i, 1'b0}),
		.sync_o(pin_sync)
	);
	wire if_sel_s = pin_sync[10];
	wire cfg_src_s = pin_sync[9];
	wire wr_ref_s = pin_sync[8];
	wire cs_n_s = pin_sync[7];
	wire [2:0] start_s = pin_sync[6:4];
	// Frame sync travels inverted so the cleared synchroniser reads as idle high after reset
	wire fs_s = ~pin_sync[3];
	wire sclk_s = pin_sync[2];
	wire sdi_s = pin_sync[1];

	logic [2:0] start_q_r;
	logic fs_q_r;
	logic sclk_q_r;
	logic wr_q_r;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			start_q_r <= 3'h0;
			fs_q_r <= 1'b1;
			sclk_q_r <= 1'b0;
			wr_q_r <= 1'b0;
		end else begin
			start_q_r <= start_s;
			fs_q_r <= fs_s;
			sclk_q_r <= sclk_s;
			wr_q_r <= wr_ref_s;
		end
	end
	wire [2:0] start_rise = start_s & ~start_q_r;
	wire fs_fall = fs_q_r & ~fs_s;
	wire fs_rise = ~fs_q_r & fs_s;
	wire sclk_rise = sclk_s & ~sclk_q_r;
	wire sclk_fall = ~sclk_s & sclk_q_r;

	// Mode latches: only refreshed while idle so a pin glitch cannot tear a transfer
	adcms_state_e state_r, state_nxt;
	logic serial_mode_r;
	logic sw_mode_r;
	wire idle = (state_r == ADCMS_IDLE) && fs_s;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			serial_mode_r <= 1'b0;
			sw_mode_r <= 1'b0;
		end else if (idle) begin
			serial_mode_r <= if_sel_s;
			sw_mode_r <= cfg_src_s;
		end
	end

	// Config register
	logic [31:0] config_r;
	wire ref_nxt = sw_mode_r ? config_r[`ADCMS_REF_ON_BIT] : wr_ref_s;

	// Conversion sequencer; busy rises on the cycle after the synchronised edge
	logic [15:0] conv_cnt_r;
	logic [15:0] res_a_r, res_b_r, res_c_r;
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ADCMS_IDLE: begin
				if (|start_rise)
					state_nxt = ADCMS_CONV;
				else if (fs_fall && serial_mode_r)
					state_nxt = ADCMS_READ;
			end
			ADCMS_CONV: begin
				if (conv_cnt_r == 16'(CONV_CYC - 1))
					state_nxt = ADCMS_IDLE;
			end
			ADCMS_READ: begin
				if (fs_rise)
					state_nxt = ADCMS_IDLE;
			end
			default: state_nxt = ADCMS_IDLE;
		endcase
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= ADCMS_IDLE;
			conv_cnt_r <= 16'h0000;
			busy_o <= 1'b0;
			ref_enable_o <= 1'b0;
		end else begin
			state_r <= state_nxt;
			conv_cnt_r <= (state_nxt == ADCMS_CONV && state_r == ADCMS_CONV) ?
				conv_cnt_r + 16'h0001 : 16'h0000;
			busy_o <= (state_nxt == ADCMS_CONV);
			ref_enable_o <= ref_nxt;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			res_a_r <= 16'h0000;
			res_b_r <= 16'h0000;
			res_c_r <= 16'h0000;
		end else if (state_r == ADCMS_CONV && state_nxt == ADCMS_IDLE) begin
			res_a_r <= result_a_i;
			res_b_r <= result_b_i;
			res_c_r <= result_c_i;
		end
	end

	// Serial readout: one shift register per pair output
	logic [15:0] shift_r [3];
	logic [15:0] serin_r;
	wire [15:0] res_all [3];
	assign res_all[0] = res_a_r;
	assign res_all[1] = res_b_r;
	assign res_all[2] = res_c_r;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_lane
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					shift_r[g] <= 16'h0000;
					serial_out_pair_o[g] <= 1'b0;
					serial_out_pair_oe_n_o[g] <= 1'b1;
				end else begin
					if (fs_fall && serial_mode_r) begin
						shift_r[g] <= {res_all[g][14:0], 1'b0};
						serial_out_pair_o[g] <= res_all[g][15];
						serial_out_pair_oe_n_o[g] <= 1'b0;
					end else if (fs_rise || !serial_mode_r) begin
						serial_out_pair_oe_n_o[g] <= 1'b1;
					end else if (sclk_rise && state_r == ADCMS_READ) begin
						serial_out_pair_o[g] <= shift_r[g][15];
						shift_r[g] <= {shift_r[g][14:0], 1'b0};
					end
				end
			end
		end
	endgenerate
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			serin_r <= 16'h0000;
		else if (sclk_fall && state_r == ADCMS_READ)
			serin_r <= {serin_r[14:0], sdi_s};
	end

	// Parallel write capture; data takes the same two stages as the strobe
	logic [15:0] parin_r;
	logic [15:0] pd_s;
	adcms_sync #(.WIDTH(16)) u_sync_pd (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.async_i(parallel_data_i),
		.sync_o(pd_s)
	);
	wire par_wr_fire = sw_mode_r && !serial_mode_r && !cs_n_s && !wr_ref_s && wr_q_r;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			parin_r <= 16'h0000;
		else if (par_wr_fire)
			parin_r <= pd_s;
	end
	// Narrow parts and serial mode keep the top bit at zero
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			parallel_data_msb_o <= 1'b0;
		else
			parallel_data_msb_o <= (RES_BITS == 16) && !serial_mode_r && res_a_r[15];
	end

	// AXI4-Lite slave: takes address and data in any order, answers the cycle after both
	logic aw_have_r, w_have_r;
	logic [7:0] awaddr_r, araddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	wire do_write = aw_have_r && w_have_r && !s_axi_bvalid;
	wire wr_cfg = (awaddr_r == `ADCMS_OFF_CONFIG);
	wire [31:0] cfg_masked;
	generate
		for (g = 0; g < 4; g++) begin : g_strb
			assign cfg_masked[g*8 +: 8] = wstrb_r[g] ? wdata_r[g*8 +: 8] : config_r[g*8 +: 8];
		end
	endgenerate
	wire [31:0] status_word = {25'h0, ref_enable_o, sw_mode_r, serial_mode_r, busy_o, state_r[2],
		state_r[1], state_r[0]};
	wire rd_hit = (araddr_r <= `ADCMS_OFF_PARIN) && (araddr_r[1:0] == 2'h0);
	logic [31:0] rd_word;
	always_comb begin
		case (araddr_r)
			`ADCMS_OFF_CONFIG: rd_word = config_r;
			`ADCMS_OFF_STATUS: rd_word = status_word;
			`ADCMS_OFF_RESULT0: rd_word = {16'h0, res_a_r};
			`ADCMS_OFF_RESULT1: rd_word = {16'h0, res_b_r};
			`ADCMS_OFF_RESULT2: rd_word = {16'h0, res_c_r};
			`ADCMS_OFF_SERIN: rd_word = {16'h0, serin_r};
			`ADCMS_OFF_PARIN: rd_word = {16'h0, parin_r};
			default: rd_word = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ADCMS_RESP_OKAY;
			config_r <= `ADCMS_CONFIG_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_cfg ? `ADCMS_RESP_OKAY : `ADCMS_RESP_SLVERR;
				if (wr_cfg)
					config_r <= cfg_masked;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	logic ar_have_r;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ar_have_r <= 1'b0;
			araddr_r <= 8'h00;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `ADCMS_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				ar_have_r <= 1'b1;
				araddr_r <= s_axi_araddr;
				s_axi_arready <= 1'b0;
			end
			if (ar_have_r && !s_axi_rvalid) begin
				ar_have_r <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? `ADCMS_RESP_OKAY : `ADCMS_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // adcms_core

// ===== adcms_core_monitor.sv
// Port checker for the ADC mode and readout block.
// Assumes it is bound into adcms_core and sees only its ports.
`timescale 1ns/1ps
module adcms_core_monitor #(
	parameter int RES_BITS = 16,
	parameter int CONV_CYC = 51
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic interface_select_i,
	input wire logic config_source_select_i,
	input wire logic write_ref_pin_i,
	input wire logic [2:0] conversion_start_pair_i,
	input wire logic busy_o,
	input wire logic ref_enable_o,
	input wire logic parallel_data_msb_o,
	input wire logic frame_sync_i,
	input wire logic serial_clock_i,
	input wire logic [2:0] serial_out_pair_o,
	input wire logic [2:0] serial_out_pair_oe_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [7:0] busy_cnt_r;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			busy_cnt_r <= 8'h00;
		else
			busy_cnt_r <= busy_o ? busy_cnt_r + 8'h01 : 8'h00;
	end
	// A start just after a frame may still be refused, so wait it out
	sequence s_start;
		frame_sync_i[*6] ##0 ($rose(|conversion_start_pair_i) && !busy_o);
	endsequence
	sequence s_open;
		$fell(frame_sync_i) && interface_select_i && !busy_o;
	endsequence
	sequence s_pin_steady;
		(!config_source_select_i && $stable(write_ref_pin_i))[*6];
	endsequence
	AST_START_BUSY: assert property (s_start |-> ##[1:4] busy_o)
		else $error("busy late after start");
	AST_BUSY_LEN: assert property ($fell(busy_o) |-> busy_cnt_r == 8'(CONV_CYC))
		else $error("busy length wrong");
	AST_OE_ON: assert property (s_open
		|-> ##[1:4] serial_out_pair_oe_n_o == 3'h0)
		else $error("serial outputs not enabled");
	AST_OE_OFF: assert property ($rose(frame_sync_i)
		|-> ##[1:4] &serial_out_pair_oe_n_o)
		else $error("serial outputs not released");
	AST_IDLE_HIZ: assert property (frame_sync_i[*5] |-> &serial_out_pair_oe_n_o)
		else $error("serial outputs driven outside frame");
	AST_MSB_ZERO: assert property ((interface_select_i || RES_BITS != 16)[*6]
		|-> !parallel_data_msb_o)
		else $error("data bit 15 not zero");
	AST_REF_PIN: assert property (s_pin_steady
		|-> ref_enable_o == write_ref_pin_i)
		else $error("reference enable not following pin");
	AST_SDO_HOLD: assert property ((!frame_sync_i && !serial_clock_i)[*6]
		|-> $stable(serial_out_pair_o))
		else $error("serial data moved without clock rise");
endmodule // adcms_core_monitor
bind adcms_core adcms_core_monitor #(.RES_BITS(RES_BITS), .CONV_CYC(CONV_CYC)) mon_u (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .interface_select_i(interface_select_i),
	.config_source_select_i(config_source_select_i), .write_ref_pin_i(write_ref_pin_i),
	.conversion_start_pair_i(conversion_start_pair_i), .busy_o(busy_o),
	.ref_enable_o(ref_enable_o), .parallel_data_msb_o(parallel_data_msb_o),
	.frame_sync_i(frame_sync_i), .serial_clock_i(serial_clock_i),
	.serial_out_pair_o(serial_out_pair_o), .serial_out_pair_oe_n_o(serial_out_pair_oe_n_o));

// ===== adcms_host.sv
// Host controller model: starts conversions and clocks out frames.
// Assumes a serial clock of 200 ns, off phase with the system clock.
`timescale 1ns/1ps
module adcms_host (
	input wire logic clk_i,
	input wire logic busy_i,
	input wire logic [2:0] sdo_i,
	output logic [2:0] start_o,
	output logic fs_o,
	output logic sclk_o,
	output logic sdi_o
);
	initial begin
		start_o = 3'h0;
		fs_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
	end
	task automatic convert(input logic [2:0] pairs);
		int n;
		n = 0;
		repeat (3) @(posedge clk_i);
		// Raised right after an edge, so it is set up a whole period before the next one
		start_o <= pairs;
		repeat (4) @(posedge clk_i);
		start_o <= 3'h0;
		while (!busy_i && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		while (busy_i && n < 400) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic frame(input logic [15:0] din, output logic [47:0] dout);
		while (busy_i) @(posedge clk_i);
		fs_o <= 1'b0;
		#263;
		for (int i = 15; i >= 0; i--) begin
			dout[i] = sdo_i[0];
			dout[16+i] = sdo_i[1];
			dout[32+i] = sdo_i[2];
			#100 sclk_o <= 1'b1;
			sdi_o <= din[i];
			#100 sclk_o <= 1'b0;
		end
		#100;
		@(posedge clk_i);
		fs_o <= 1'b1;
		// Released input must not keep its last bit
		sdi_o <= ~sdi_o;
	endtask
endmodule // adcms_host

// ===== adcms_pkg.sv
// Types shared by the ADC mode and serial readout block.
// Assumes nothing beyond the constant header.
package adcms_pkg;
	typedef enum logic [2:0] {
		ADCMS_IDLE = 3'b001,
		ADCMS_CONV = 3'b010,
		ADCMS_READ = 3'b100
	} adcms_state_e;
	typedef logic [15:0] adcms_word_t;
endpackage

// ===== adcms_regs.svh
// Register offsets, field positions, reset values and timing counts for the ADC mode block.
// Assumes a 40 MHz system clock; included by the package user files by bare name.
`ifndef ADCMS_REGS_SVH
`define ADCMS_REGS_SVH

`define ADCMS_CLK_PERIOD_PS 25000
// Register byte offsets
`define ADCMS_OFF_CONFIG 8'h00
`define ADCMS_OFF_STATUS 8'h04
`define ADCMS_OFF_RESULT0 8'h08
`define ADCMS_OFF_RESULT1 8'h0C
`define ADCMS_OFF_RESULT2 8'h10
`define ADCMS_OFF_SERIN 8'h14
`define ADCMS_OFF_PARIN 8'h18
// Config register fields
`define ADCMS_REF_ON_BIT 25
`define ADCMS_CONFIG_RESET 32'h0000_0000
// Timing figures in ns and derived cycle counts
`define ADCMS_BUSY_MAX_NS 20
`define ADCMS_BUSY_CYC ((`ADCMS_BUSY_MAX_NS * 1000) / `ADCMS_CLK_PERIOD_PS)
`define ADCMS_CONV_NS 1260
`define ADCMS_CONV_CYC (((`ADCMS_CONV_NS * 1000) + `ADCMS_CLK_PERIOD_PS - 1) / `ADCMS_CLK_PERIOD_PS)
`define ADCMS_RESP_OKAY 2'h0
`define ADCMS_RESP_SLVERR 2'h2

`endif

// ===== adcms_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins.
// Assumes one system clock; first stage read only by the second.
`timescale 1ns/1ps
module adcms_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule // adcms_sync
